// >>> hdl/ipw_prio_word.sv
// Interrupt priority word zero: three 3-bit priority fields behind an AXI4-Lite slave.
// Assumes one clock, synchronous active-low reset and synchronous source request inputs.
`timescale 1ns/10ps
module ipw_prio_word (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Raw requests: 2 compare1, 1 capture1, 0 ext irq0
    input wire logic [2:0] src_req,
    // Decoded priorities and gated requests
    output logic [2:0] compare1_irq_priority,
    output logic [2:0] capture1_irq_priority,
    output logic [2:0] ext_irq0_priority,
    output logic [2:0] src_enabled,
    output logic [2:0] irq_req
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [15:0] irq_priority_word_zero;
    logic [15:0] next_word;
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [31:0] aw_addr_q, next_aw_addr_q;
    logic [31:0] w_data_q, next_w_data_q;
    logic [3:0] w_strb_q, next_w_strb_q;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic write_fire;
    logic [15:0] wmask;
    logic [2:0] codes [ipw_pkg::NUM_SOURCES];
    logic [2:0] levels [ipw_pkg::NUM_SOURCES];
    logic [2:0] dec_en;
    logic [2:0] next_c1, next_k1, next_e0, next_en, next_irq;

    // ----------------------------------------
    // Bus slave and register
    // ----------------------------------------
    // Write and read channels, next values
    always_comb begin
        next_word = irq_priority_word_zero;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr_q = aw_addr_q;
        next_w_data_q = w_data_q;
        next_w_strb_q = w_strb_q;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        wmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}} & ipw_pkg::PRIO_WORD_MASK;
        write_fire = aw_held && w_held && !bvalid;
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_aw_addr_q = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_w_data_q = wdata;
            next_w_strb_q = wstrb;
        end
        if (write_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            if (aw_addr_q[31:2] == ipw_pkg::PRIO_WORD_ADDR[31:2]) begin
                next_word = (irq_priority_word_zero & ~wmask) | (w_data_q[15:0] & wmask);
                next_bresp = ipw_pkg::RESP_OKAY;
            end else begin
                next_bresp = ipw_pkg::RESP_SLVERR;
            end
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            if (araddr[31:2] == ipw_pkg::PRIO_WORD_ADDR[31:2]) begin
                next_rdata = {16'h0000, irq_priority_word_zero & ipw_pkg::PRIO_WORD_MASK};
                next_rresp = ipw_pkg::RESP_OKAY;
            end else begin
                next_rdata = 32'h0000_0000;
                next_rresp = ipw_pkg::RESP_SLVERR;
            end
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    // Bus and register flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_priority_word_zero <= ipw_pkg::PRIO_WORD_RESET;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 32'h0000_0000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rresp <= 2'h0;
            rdata <= 32'h0000_0000;
        end else begin
            irq_priority_word_zero <= next_word;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr_q <= next_aw_addr_q;
            w_data_q <= next_w_data_q;
            w_strb_q <= next_w_strb_q;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // Priority decode
    // ----------------------------------------
    // compare1 field bits 10-8
    assign codes[2] = irq_priority_word_zero[ipw_pkg::COMPARE1_LSB +: 3];
    assign codes[1] = irq_priority_word_zero[ipw_pkg::CAPTURE1_LSB +: 3];
    assign codes[0] = irq_priority_word_zero[ipw_pkg::EXT0_LSB +: 3];

    // One decoder per source
    for (genvar i = 0; i < ipw_pkg::NUM_SOURCES; i++) begin : g_dec
        ipw_prio_decode u_dec (
            .code(codes[i]),
            .level(levels[i]),
            .enabled(dec_en[i])
        );
    end

    // levels follow codes; disabled sources gated off
    always_comb begin
        next_c1 = levels[2];
        next_k1 = levels[1];
        next_e0 = levels[0];
        next_en = dec_en;
        next_irq = src_req & dec_en;
    end

    // Decoded output flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare1_irq_priority <= 3'h0;
            capture1_irq_priority <= 3'h0;
            ext_irq0_priority <= 3'h0;
            src_enabled <= 3'h0;
            irq_req <= 3'h0;
        end else begin
            compare1_irq_priority <= next_c1;
            capture1_irq_priority <= next_k1;
            ext_irq0_priority <= next_e0;
            src_enabled <= next_en;
            irq_req <= next_irq;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_aw_taken;
        awvalid && awready;
    endsequence

    sequence s_resp_seen;
        ##[1:3] bvalid;
    endsequence

    a_write_gets_resp: assert property (s_aw_taken |-> s_resp_seen)
        else $error("write response missing");

    a_rsvd_read_zero: assert property (rvalid |-> (rdata[31:16] == 16'h0000)
        && !rdata[11] && !rdata[7] && !rdata[3] && !rdata[15])
        else $error("reserved bits read nonzero");

    a_rsvd_bits_stay: assert property ((irq_priority_word_zero & ~ipw_pkg::PRIO_WORD_MASK)
        == 16'h0000)
        else $error("reserved bit stored");

    a_cmp_field_write: assert property (write_fire
        && aw_addr_q[31:2] == 30'h0 && w_strb_q[1]
        |=> irq_priority_word_zero[10:8] == $past(w_data_q[10:8]))
        else $error("compare1 field not written");

    a_cap_field_write: assert property (write_fire && aw_addr_q[31:2] == 30'h0
        && w_strb_q[0] |=> irq_priority_word_zero[6:4] == $past(w_data_q[6:4]))
        else $error("capture1 field not written");

    a_ext_field_write: assert property (write_fire && aw_addr_q[31:2] == 30'h0
        && w_strb_q[0] |=> irq_priority_word_zero[2:0] == $past(w_data_q[2:0])
        ##1 ext_irq0_priority == $past(w_data_q[2:0], 2))
        else $error("ext irq0 field not written");

    a_code_top_level: assert property (irq_priority_word_zero[10:8] == 3'h7
        |=> compare1_irq_priority == 3'h7 && src_enabled[2])
        else $error("code 111 not level 7");

    a_code_linear_map: assert property ($past(aresetn) && irq_priority_word_zero[6:4] != 3'h0
        |=> capture1_irq_priority == $past(irq_priority_word_zero[6:4]) && src_enabled[1])
        else $error("level does not follow code");

    a_disabled_no_req: assert property (irq_priority_word_zero[2:0] == 3'h0
        |=> !irq_req[0] && !src_enabled[0])
        else $error("disabled source raised request");
endmodule

// >>> hdl/ipw_pkg.sv
// Constants for the interrupt priority word zero block.
// Assumes a 32-bit AXI4-Lite register bus and one 25 MHz clock.
package ipw_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [31:0] PRIO_WORD_ADDR = 32'h0000_0000;
    localparam logic [15:0] PRIO_WORD_RESET = 16'h0444;
    localparam logic [15:0] PRIO_WORD_MASK = 16'h0777;
    // ----------------------------------------
    // Field positions (low bit of each field)
    // ----------------------------------------
    localparam int COMPARE1_LSB = 8;
    localparam int CAPTURE1_LSB = 4;
    localparam int EXT0_LSB = 0;
    localparam int NUM_SOURCES = 3;
    // ----------------------------------------
    // Field codes and bus answers
    // ----------------------------------------
    localparam logic [2:0] CODE_DISABLED = 3'h0;
    localparam logic [2:0] CODE_HIGHEST = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> hdl/ipw_prio_decode.sv
// Decodes one 3-bit priority code into a level and an enable.
// Assumes the code comes from a register of the same clock domain.
`timescale 1ns/10ps
module ipw_prio_decode (
    // Field code
    input wire logic [2:0] code,
    // Decoded result
    output logic [2:0] level,
    output logic enabled
);
    // Codes map straight onto levels, zero disables the source
    always_comb begin
        level = code;
        enabled = (code != ipw_pkg::CODE_DISABLED);
    end
endmodule

// >>> tb/ipw_prio_word_tb.sv
// Self-checking bench for the interrupt priority word zero block.
// Assumes the block's AXI4-Lite slave and the constants in ipw_pkg.
`timescale 1ns/10ps
module ipw_prio_word_tb;
    // ----------------------------------------
    // Signals and bench state
    // ----------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic [2:0] src_req = 3'h0, c1_prio, cap_prio, ext_prio, src_enabled, irq_req;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid;
    logic [15:0] model_word;
    logic [31:0] d, a;
    int failures = 0, cmp_count = 0, cycles = 0, seed;

    ipw_prio_word i_ipw_prio_word (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .src_req(src_req), .compare1_irq_priority(c1_prio),
        .capture1_irq_priority(cap_prio), .ext_irq0_priority(ext_prio),
        .src_enabled(src_enabled), .irq_req(irq_req));

    // Clock and hang guard
    initial forever #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    // ----------------------------------------
    // Compare and report
    // ----------------------------------------
    task print_verdict();
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk_word(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task chk_fld(input logic [2:0] g, input logic [2:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // ----------------------------------------
    // Bus tasks with the reference model
    // ----------------------------------------
    task wr_word(input logic [31:0] ad, input logic [31:0] dt, input logic [3:0] st);
        logic hit;
        hit = (ad[31:2] == 30'h0);
        if (hit && st[0]) model_word[7:0] = dt[7:0];
        if (hit && st[1]) model_word[15:8] = dt[15:8];
        model_word = model_word & ipw_pkg::PRIO_WORD_MASK;
        @(posedge aclk);
        awaddr <= ad; wdata <= dt; wstrb <= st; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        chk_word({30'h0, bresp}, {30'h0, hit ? ipw_pkg::RESP_OKAY : ipw_pkg::RESP_SLVERR});
    endtask
    task rd_check(input logic [31:0] ad);
        logic hit;
        hit = (ad[31:2] == 30'h0);
        @(posedge aclk);
        araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        chk_word(rdata, hit ? {16'h0, model_word} : 32'h0);
        chk_word({30'h0, rresp}, {30'h0, hit ? ipw_pkg::RESP_OKAY : ipw_pkg::RESP_SLVERR});
    endtask
    // Decoded levels, enables and gated requests
    task check_dec();
        logic [2:0] en, r;
        en = {|model_word[10:8], |model_word[6:4], |model_word[2:0]};
        r = 3'($urandom);
        @(negedge aclk);
        chk_fld(c1_prio, model_word[10:8]);
        chk_fld(cap_prio, model_word[6:4]);
        chk_fld(ext_prio, model_word[2:0]);
        chk_fld(src_enabled, en);
        @(posedge aclk);
        src_req <= r;
        @(posedge aclk);
        @(negedge aclk);
        chk_fld(irq_req, r & en);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = $urandom(32'h39f3);
        model_word = ipw_pkg::PRIO_WORD_RESET;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        // Decoded outputs load at the first edge that sees reset released
        @(posedge aclk);
        check_dec();
        rd_check(32'h0);
        // Every code in every field, with every unused bit set to one
        for (int c = 0; c < 8; c++) begin
            d = $urandom | 32'hffff_f888;
            d[10:8] = 3'(c);
            d[6:4] = 3'(c);
            d[2:0] = 3'(c);
            wr_word(32'h0, d, 4'hf);
            rd_check(32'h0);
            check_dec();
        end
        // Unmapped place leaves the word alone
        wr_word(32'h0000_0010, 32'h0, 4'hf);
        rd_check(32'h0000_0010);
        // Random addresses, data and strobes
        repeat (30) begin
            a = ($urandom % 4 != 0) ? ($urandom & 32'h3) : $urandom;
            wr_word(a, $urandom, 4'($urandom));
            rd_check(32'h0);
            check_dec();
        end
        // Second reset in mid-run restores the word
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        model_word = ipw_pkg::PRIO_WORD_RESET;
        rd_check(32'h0);
        check_dec();
        print_verdict();
    end
endmodule
